// [rtl/sbg_pkg.sv]
// Shared constants and types for the stack bounds checker and secure RAM guard.
package sbg_pkg;

    // ------------------------------------------------------------------
    // Data path widths
    // ------------------------------------------------------------------
    localparam int unsigned SBG_AW = 16;
    localparam int unsigned SBG_PC_HI_W = 7;
    localparam int unsigned SBG_SRL_W = 8;

    // ------------------------------------------------------------------
    // Stack pointer constants
    // ------------------------------------------------------------------
    // Addresses below this word belong to peripheral register space.
    localparam logic [15:0] SBG_SP_LOWER_BOUND = 16'h0800;
    localparam logic [15:0] SBG_SP_RESET_VAL = 16'h0800;
    localparam logic [15:0] SBG_WORD_STEP = 16'h0002;

    // ------------------------------------------------------------------
    // Secure RAM segments
    // ------------------------------------------------------------------
    localparam int unsigned SBG_SEG_N = 2;
    localparam int unsigned SBG_SEG_BOOT = 0;
    localparam int unsigned SBG_SEG_SECURE = 1;

    // ------------------------------------------------------------------
    // Kinds of word pushed onto the stack
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SBG_PUSH_DATA = 2'b00,
        SBG_PUSH_CALL = 2'b01,
        SBG_PUSH_EXC = 2'b11
    } sbg_push_type;

endpackage : sbg_pkg

// [rtl/sbg_ram_guard.sv]
// Secure RAM segment access filter, one check per protected segment.
`timescale 1ns/1ps

module sbg_ram_guard
    import sbg_pkg::*;
(
    // Access being checked
    input wire logic req_i,
    input wire logic [15:0] addr_i,
    // Per-segment controls, bit index is the segment number
    input wire logic [SBG_SEG_N-1:0] seg_en_i,
    input wire logic [SBG_SEG_N-1:0] code_in_seg_i,
    input wire logic [SBG_SEG_N-1:0][15:0] seg_lo_i,
    input wire logic [SBG_SEG_N-1:0][15:0] seg_hi_i,
    // Verdict
    output logic blocked_o
);

    logic [SBG_SEG_N-1:0] seg_hit;

    // ------------------------------------------------------------------
    // Per-segment ownership check
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < SBG_SEG_N; g = g + 1) begin : g_seg
            // RL11: RL12: owner code only.
            // A segment blocks only while enabled and only code running from its own flash segment passes.
            assign seg_hit[g] = seg_en_i[g] && !code_in_seg_i[g] &&
                                (addr_i >= seg_lo_i[g]) && (addr_i <= seg_hi_i[g]);
        end
    endgenerate

    assign blocked_o = req_i && (|seg_hit);

endmodule : sbg_ram_guard

// [rtl/sbg_stack_guard.sv]
// Stack pointer, stack limit checking and secure RAM guard for a 16-bit core.
// Function
// RL1: Working register serves as stack pointer, next free.
// RL2: Stack grows upward; push post-increments, pop pre-decrements.
// RL3: Call pushes program counter with MSB cleared.
// RL4: Exception push puts status low byte in MSB.
// RL5: Stack limit register is never reset.
// RL6: Stack limit bit zero always zero.
// RL7: Every stack pointer address compared against limit.
// RL8: Push at limit is fine; next one traps.
// RL9: Address below lower bound raises underflow trap.
// RL10: Core avoids stack read right after limit write.
// RL11: Boot secure RAM only for boot flash code.
// RL12: Secure RAM only for secure flash code.
// RL13: Trap is one-cycle pulse with the comparison.
`timescale 1ns/1ps

module sbg_stack_guard
    import sbg_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Direct stack pointer write from the core
    input wire logic sp_wr_i,
    input wire logic [15:0] sp_wdata_i,
    // Stack limit write from the core
    input wire logic limit_wr_i,
    input wire logic [15:0] limit_wdata_i,
    // Push and pop requests
    input wire logic push_i,
    input wire sbg_push_type push_sel_i,
    input wire logic [15:0] push_data_i,
    input wire logic [SBG_PC_HI_W-1:0] pc_hi_i,
    input wire logic [SBG_SRL_W-1:0] status_low_byte_i,
    input wire logic pop_i,
    // Other effective addresses formed from the stack pointer
    input wire logic ea_sp_i,
    input wire logic [15:0] ea_i,
    // Data access to be filtered by the secure RAM guard
    input wire logic data_req_i,
    input wire logic [15:0] data_addr_i,
    input wire logic code_in_boot_i,
    input wire logic code_in_secure_i,
    input wire logic boot_secure_ram_segment_en_i,
    input wire logic secure_segment_ram_en_i,
    input wire logic [15:0] boot_seg_lo_i,
    input wire logic [15:0] boot_seg_hi_i,
    input wire logic [15:0] secure_seg_lo_i,
    input wire logic [15:0] secure_seg_hi_i,
    // Stack memory access
    output logic mem_wr_o,
    output logic mem_rd_o,
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    output logic [15:0] sp_o,
    // Trap requests to the exception logic
    output logic stack_trap_o,
    output logic stack_ovf_o,
    output logic stack_unf_o,
    // Data access verdict
    output logic data_grant_o,
    output logic data_block_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] stack_pointer_working_reg_r, stack_pointer_working_reg_nxt;
    logic [15:1] stack_limit_reg_r, stack_limit_reg_nxt;
    logic [15:0] limit_val;
    logic mem_wr_r, mem_wr_nxt;
    logic mem_rd_r, mem_rd_nxt;
    logic [15:0] mem_addr_r, mem_addr_nxt;
    logic [15:0] mem_wdata_r, mem_wdata_nxt;
    logic trap_r, trap_nxt;
    logic ovf_r, ovf_nxt;
    logic unf_r, unf_nxt;
    logic grant_r, grant_nxt;
    logic block_r, block_nxt;
    logic guard_blocked;
    logic chk_en;
    logic [15:0] chk_ea;
    logic [15:0] push_word;

    // RL6: limit forced aligned.
    assign limit_val = {stack_limit_reg_r, 1'b0};

    // ------------------------------------------------------------------
    // Secure RAM guard
    // ------------------------------------------------------------------
    sbg_ram_guard u_guard (
        .req_i(data_req_i),
        .addr_i(data_addr_i),
        .seg_en_i({secure_segment_ram_en_i, boot_secure_ram_segment_en_i}),
        .code_in_seg_i({code_in_secure_i, code_in_boot_i}),
        .seg_lo_i({secure_seg_lo_i, boot_seg_lo_i}),
        .seg_hi_i({secure_seg_hi_i, boot_seg_hi_i}),
        .blocked_o(guard_blocked)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        stack_pointer_working_reg_nxt = stack_pointer_working_reg_r;
        mem_wr_nxt = 1'b0;
        mem_rd_nxt = 1'b0;
        mem_addr_nxt = mem_addr_r;
        mem_wdata_nxt = mem_wdata_r;
        chk_en = 1'b0;
        chk_ea = stack_pointer_working_reg_r;
        ovf_nxt = 1'b0;
        unf_nxt = 1'b0;
        // RL5: RL6: limit keeps only bits above zero.
        stack_limit_reg_nxt = limit_wr_i ? limit_wdata_i[15:1] : stack_limit_reg_r;
        case (push_sel_i)
            // RL3: call clears MSB.
            SBG_PUSH_CALL: push_word = {9'h000, pc_hi_i};
            // RL4: exception inserts status byte.
            SBG_PUSH_EXC: push_word = {status_low_byte_i, 1'b0, pc_hi_i};
            default: push_word = push_data_i;
        endcase
        // A direct pointer write wins over any stack operation in the same cycle.
        if (sp_wr_i) begin
            stack_pointer_working_reg_nxt = {sp_wdata_i[15:1], 1'b0};
        end else if (push_i) begin
            // RL1: RL2: store then increment.
            mem_wr_nxt = 1'b1;
            mem_addr_nxt = stack_pointer_working_reg_r;
            mem_wdata_nxt = push_word;
            stack_pointer_working_reg_nxt = stack_pointer_working_reg_r + SBG_WORD_STEP;
            chk_en = 1'b1;
            chk_ea = stack_pointer_working_reg_r;
        end else if (pop_i) begin
            // RL2: decrement then read.
            mem_rd_nxt = 1'b1;
            mem_addr_nxt = stack_pointer_working_reg_r - SBG_WORD_STEP;
            stack_pointer_working_reg_nxt = stack_pointer_working_reg_r - SBG_WORD_STEP;
            chk_en = 1'b1;
            chk_ea = stack_pointer_working_reg_r - SBG_WORD_STEP;
        end else if (ea_sp_i) begin
            chk_en = 1'b1;
            chk_ea = ea_i;
        end
        // RL7: RL8: compare against limit.
        // The limit itself is a legal slot, so only an address past it overflows.
        if (chk_en) begin
            ovf_nxt = chk_ea > limit_val;
            // RL9: below lower bound.
            unf_nxt = chk_ea < SBG_SP_LOWER_BOUND;
        end
        // RL13: one-cycle trap request.
        trap_nxt = ovf_nxt || unf_nxt;
        grant_nxt = data_req_i && !guard_blocked;
        block_nxt = guard_blocked;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // RL5: no reset on the limit.
    // Software must write the limit before relying on overflow traps.
    always_ff @(posedge mclk_i) begin
        stack_limit_reg_r <= stack_limit_reg_nxt;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            stack_pointer_working_reg_r <= SBG_SP_RESET_VAL;
            mem_wr_r <= 1'b0;
            mem_rd_r <= 1'b0;
            mem_addr_r <= 16'h0000;
            mem_wdata_r <= 16'h0000;
            trap_r <= 1'b0;
            ovf_r <= 1'b0;
            unf_r <= 1'b0;
            grant_r <= 1'b0;
            block_r <= 1'b0;
        end else begin
            stack_pointer_working_reg_r <= stack_pointer_working_reg_nxt;
            mem_wr_r <= mem_wr_nxt;
            mem_rd_r <= mem_rd_nxt;
            mem_addr_r <= mem_addr_nxt;
            mem_wdata_r <= mem_wdata_nxt;
            trap_r <= trap_nxt;
            ovf_r <= ovf_nxt;
            unf_r <= unf_nxt;
            grant_r <= grant_nxt;
            block_r <= block_nxt;
        end
    end

    assign mem_wr_o = mem_wr_r;
    assign mem_rd_o = mem_rd_r;
    assign mem_addr_o = mem_addr_r;
    assign mem_wdata_o = mem_wdata_r;
    assign sp_o = stack_pointer_working_reg_r;
    assign stack_trap_o = trap_r;
    assign stack_ovf_o = ovf_r;
    assign stack_unf_o = unf_r;
    assign data_grant_o = grant_r;
    assign data_block_o = block_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_push_store: assert property ( // RL1
        @(posedge mclk_i) disable iff (rst_i)
        (push_i && !sp_wr_i) |=> (mem_wr_o && !mem_rd_o && mem_addr_o == $past(sp_o)))
        else $error("push did not store at the free word");

    chk_push_incr: assert property ( // RL2
        @(posedge mclk_i) disable iff (rst_i)
        (push_i && !sp_wr_i) |=> (sp_o == $past(sp_o) + SBG_WORD_STEP))
        else $error("push did not advance the pointer by one word");

    chk_pop_decr: assert property ( // RL2
        @(posedge mclk_i) disable iff (rst_i)
        (pop_i && !push_i && !sp_wr_i) |=> (mem_rd_o && sp_o == mem_addr_o &&
                                             sp_o == $past(sp_o) - SBG_WORD_STEP))
        else $error("pop did not pre-decrement and read");

    chk_call_msb: assert property ( // RL3
        @(posedge mclk_i) disable iff (rst_i)
        (push_i && !sp_wr_i && push_sel_i == SBG_PUSH_CALL) |=> (mem_wdata_o[15:7] == 9'h000))
        else $error("call push left upper bits set");

    chk_exc_status: assert property ( // RL4
        @(posedge mclk_i) disable iff (rst_i)
        (push_i && !sp_wr_i && push_sel_i == SBG_PUSH_EXC) |=>
        (mem_wdata_o[15:8] == $past(status_low_byte_i) && mem_wdata_o[6:0] == $past(pc_hi_i)))
        else $error("exception push lost the status byte");

    chk_limit_align: assert property ( // RL6
        @(posedge mclk_i) disable iff (rst_i)
        limit_wr_i |=> (limit_val == {$past(limit_wdata_i[15:1]), 1'b0}))
        else $error("stack limit not word aligned");

    chk_ea_ovf: assert property ( // RL7
        @(posedge mclk_i) disable iff (rst_i)
        (ea_sp_i && !push_i && !pop_i && !sp_wr_i && !limit_wr_i && ea_i > limit_val) |=>
        (stack_ovf_o && stack_trap_o))
        else $error("address past the limit did not trap");

    chk_limit_edge: assert property ( // RL8
        @(posedge mclk_i) disable iff (rst_i)
        (push_i && !sp_wr_i && sp_o == limit_val && sp_o >= SBG_SP_LOWER_BOUND) |=>
        (!stack_trap_o ##1 1'b1))
        else $error("push at the limit trapped");

    chk_limit_next: assert property ( // RL8
        @(posedge mclk_i) disable iff (rst_i)
        (push_i && !sp_wr_i && !limit_wr_i && sp_o == limit_val &&
         limit_val != 16'hFFFE && sp_o >= SBG_SP_LOWER_BOUND) ##1
        (push_i && !sp_wr_i) |=> (stack_trap_o && stack_ovf_o))
        else $error("second push past the limit did not trap");

    chk_underflow: assert property ( // RL9
        @(posedge mclk_i) disable iff (rst_i)
        (ea_sp_i && !push_i && !pop_i && !sp_wr_i && ea_i < SBG_SP_LOWER_BOUND) |=>
        (stack_unf_o && stack_trap_o))
        else $error("address below the lower bound did not trap");

    chk_trap_cause: assert property ( // RL13
        @(posedge mclk_i) disable iff (rst_i)
        !(push_i || pop_i || ea_sp_i) |=> !stack_trap_o)
        else $error("trap raised without a comparison");

    chk_boot_block: assert property ( // RL11
        @(posedge mclk_i) disable iff (rst_i)
        (data_req_i && boot_secure_ram_segment_en_i && !code_in_boot_i &&
         data_addr_i >= boot_seg_lo_i && data_addr_i <= boot_seg_hi_i) |=>
        (data_block_o && !data_grant_o))
        else $error("boot secure RAM reached by foreign code");

    chk_secure_block: assert property ( // RL12
        @(posedge mclk_i) disable iff (rst_i)
        (data_req_i && secure_segment_ram_en_i && !code_in_secure_i &&
         data_addr_i >= secure_seg_lo_i && data_addr_i <= secure_seg_hi_i) |=>
        (data_block_o && !data_grant_o))
        else $error("secure RAM reached by foreign code");

endmodule : sbg_stack_guard

// [testbench/sbg_core_mem.sv]
// Core-side stack memory model answering the guard's stack reads and writes.
`timescale 1ns/1ps

module sbg_core_mem
    import sbg_pkg::*;
(
    // Clock
    input wire logic mclk_i,
    // Stack accesses from the guard
    input wire logic mem_wr_i,
    input wire logic mem_rd_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [15:0] mem_wdata_i,
    // Read answer
    output logic [15:0] rd_data_o
);
    logic [15:0] store [int];

    always @(posedge mclk_i) begin
        if (mem_wr_i) begin
            store[int'(mem_addr_i)] = mem_wdata_i;
        end
    end

    // Words never written answer with the inverted address, so a stale value cannot pass.
    always @(mem_rd_i, mem_addr_i) begin
        rd_data_o = ~mem_addr_i;
        if (mem_rd_i && store.exists(int'(mem_addr_i))) begin
            rd_data_o = store[int'(mem_addr_i)];
        end
    end
endmodule : sbg_core_mem

// [testbench/tb.sv]
// Self-checking bench for the stack bounds checker and secure RAM guard.
`timescale 1ns/1ps

module tb
    import sbg_pkg::*;
;
    logic mclk_i, rst_i, sp_wr_i, limit_wr_i, push_i, pop_i, ea_sp_i, data_req_i;
    logic code_in_boot_i, code_in_secure_i, boot_en, sec_en;
    logic [15:0] sp_wdata_i, limit_wdata_i, push_data_i, ea_i, data_addr_i, rd_data;
    sbg_push_type push_sel_i;
    logic [6:0] pc_hi_i;
    logic [7:0] status_low_byte_i;
    logic mem_wr_o, mem_rd_o, stack_trap_o, stack_ovf_o, stack_unf_o, data_grant_o, data_block_o;
    logic [15:0] mem_addr_o, mem_wdata_o, sp_o;
    logic [15:0] sp, lim, e_addr, e_wdata;
    logic e_wr, e_rd, e_ovf, e_unf, e_gr, e_bl, pv;
    logic [15:0] shadow [int];
    logic [31:0] seed;
    int failures, num_checks;

    sbg_stack_guard dut (.mclk_i(mclk_i), .rst_i(rst_i), .sp_wr_i(sp_wr_i), .sp_wdata_i(sp_wdata_i),
        .limit_wr_i(limit_wr_i), .limit_wdata_i(limit_wdata_i), .push_i(push_i), .push_sel_i(push_sel_i),
        .push_data_i(push_data_i), .pc_hi_i(pc_hi_i), .status_low_byte_i(status_low_byte_i), .pop_i(pop_i),
        .ea_sp_i(ea_sp_i), .ea_i(ea_i), .data_req_i(data_req_i), .data_addr_i(data_addr_i),
        .code_in_boot_i(code_in_boot_i), .code_in_secure_i(code_in_secure_i),
        .boot_secure_ram_segment_en_i(boot_en), .secure_segment_ram_en_i(sec_en),
        .boot_seg_lo_i(16'h0900), .boot_seg_hi_i(16'h09FF), .secure_seg_lo_i(16'h0A00),
        .secure_seg_hi_i(16'h0AFF), .mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .sp_o(sp_o), .stack_trap_o(stack_trap_o), .stack_ovf_o(stack_ovf_o),
        .stack_unf_o(stack_unf_o), .data_grant_o(data_grant_o), .data_block_o(data_block_o));

    sbg_core_mem mem (.mclk_i(mclk_i), .mem_wr_i(mem_wr_o), .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .rd_data_o(rd_data));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic complete_run();
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------------
    // One request per cycle; the answer of the previous one is checked here.
    // ------------------------------------------------------------------
    task automatic step(input int op, input logic [15:0] d, input logic [1:0] sel);
        logic [31:0] r;
        logic [15:0] da;
        r = rnd();
        da = 16'h08F0 + 16'(int'(r[31:22]) % 544);
        @(posedge mclk_i);
        sp_wr_i <= (op == 4);
        limit_wr_i <= (op == 5);
        push_i <= (op == 1);
        pop_i <= (op == 2);
        ea_sp_i <= (op == 3);
        sp_wdata_i <= d;
        limit_wdata_i <= d;
        push_data_i <= d;
        ea_i <= d;
        push_sel_i <= sbg_push_type'(sel);
        pc_hi_i <= r[6:0];
        status_low_byte_i <= r[15:8];
        data_req_i <= r[16];
        code_in_boot_i <= r[17];
        code_in_secure_i <= r[18];
        boot_en <= r[19];
        sec_en <= r[20];
        data_addr_i <= da;
        #1;
        if (pv) begin
            chk("mem_wr", 16'(e_wr), 16'(mem_wr_o));
            chk("mem_rd", 16'(e_rd), 16'(mem_rd_o));
            if (e_wr || e_rd) chk("mem_addr", e_addr, mem_addr_o);
            if (e_wr) chk("mem_wdata", e_wdata, mem_wdata_o);
            if (e_rd && shadow.exists(int'(e_addr))) chk("pop_data", shadow[int'(e_addr)], rd_data);
            chk("sp", sp, sp_o);
            chk("ovf", 16'(e_ovf), 16'(stack_ovf_o));
            chk("unf", 16'(e_unf), 16'(stack_unf_o));
            chk("trap", 16'(e_ovf | e_unf), 16'(stack_trap_o));
            chk("grant", 16'(e_gr), 16'(data_grant_o));
            chk("block", 16'(e_bl), 16'(data_block_o));
        end
        pv = 1'b1;
        e_wr = (op == 1);
        e_rd = (op == 2);
        e_addr = d;
        e_wdata = (sel == 2'b01) ? {9'h000, r[6:0]} : (sel == 2'b11) ? {r[15:8], 1'b0, r[6:0]} : d;
        if (op == 1) begin
            e_addr = sp;
            shadow[int'(sp)] = e_wdata;
            sp = sp + 16'h0002;
        end
        if (op == 2) begin
            sp = sp - 16'h0002;
            e_addr = sp;
        end
        if (op == 4) sp = d & 16'hFFFE;
        if (op == 5) lim = d & 16'hFFFE;
        e_ovf = (op >= 1 && op <= 3) && (e_addr > lim);
        e_unf = (op >= 1 && op <= 3) && (e_addr < 16'h0800);
        e_bl = r[16] && ((r[19] && !r[17] && da >= 16'h0900 && da <= 16'h09FF)
            || (r[20] && !r[18] && da >= 16'h0A00 && da <= 16'h0AFF));
        e_gr = r[16] && !e_bl;
    endtask : step

    task automatic do_reset();
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1;
        chk("reset_sp", 16'h0800, sp_o);
        chk("reset_pulses", 16'h0000, 16'({mem_wr_o, mem_rd_o, stack_trap_o, data_grant_o, data_block_o}));
        sp = 16'h0800;
        pv = 1'b0;
    endtask : do_reset

    initial begin
        int op;
        int last;
        logic [31:0] r;
        {sp_wr_i, limit_wr_i, push_i, pop_i, ea_sp_i, data_req_i} = 6'h00;
        {code_in_boot_i, code_in_secure_i, boot_en, sec_en, pc_hi_i, status_low_byte_i} = 19'h0_0000;
        {sp_wdata_i, limit_wdata_i, push_data_i, ea_i, data_addr_i} = 80'h0;
        push_sel_i = SBG_PUSH_DATA;
        rst_i = 1'b1;
        seed = 32'h0000_005D;
        lim = 16'h0000;
        do_reset();
        step(5, 16'h0803, 2'b00);
        step(0, 16'h0000, 2'b00);
        step(1, 16'h1234, 2'b00);
        step(1, 16'h5678, 2'b10);
        step(1, 16'h9ABC, 2'b00);
        repeat (4) step(2, 16'h0000, 2'b00);
        step(4, 16'h0A01, 2'b00);
        step(1, 16'hFFFF, 2'b01);
        step(1, 16'hFFFF, 2'b11);
        step(3, 16'h07FE, 2'b00);
        step(3, 16'h0A02, 2'b00);
        last = 0;
        for (int i = 0; i < 400; i++) begin
            r = rnd();
            op = int'(r[2:0]) % 6;
            // no stack read after a limit write.
            if (last == 5 && (op == 2 || op == 3)) op = 0;
            step(op, 16'h07F0 + 16'(r[31:23]), r[4:3]);
            last = op;
        end
        step(5, 16'h07FE, 2'b00);
        step(0, 16'h0000, 2'b00);
        step(0, 16'h0000, 2'b00);
        do_reset();
        step(1, 16'h1111, 2'b00);
        step(0, 16'h0000, 2'b00);
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge mclk_i);
        failures++;
        complete_run();
    end
endmodule : tb
